// >>> cmo_regs.vh
`ifndef CMO_REGS_VH
`define CMO_REGS_VH

// Register byte offsets on the Wishbone bus
`define CMO_REG_CTRL        8'h00
`define CMO_REG_STATUS      8'h04
`define CMO_REG_OPCOUNT     8'h08
`define CMO_REG_IVALID      8'h0C

// Control register fields and reset value
`define CMO_CTRL_DCACHE     0
`define CMO_CTRL_ICACHE     1
`define CMO_CTRL_USER       2
`define CMO_CTRL_INVHIT_EN  3
`define CMO_CTRL_RESET      4'hB

// Status register fields
`define CMO_STAT_BUSY       0
`define CMO_STAT_EXC_LO     4
`define CMO_STAT_HIT        8

// Instruction fields
`define CMO_F_OP_HI         5
`define CMO_F_OP_LO         0
`define CMO_F_A_HI          31
`define CMO_F_A_LO          27
`define CMO_F_B_HI          26
`define CMO_F_B_LO          22
`define CMO_F_C_HI          21
`define CMO_F_C_LO          17
`define CMO_F_OPX_HI        16
`define CMO_F_OPX_LO        11
`define CMO_F_IMM_HI        21
`define CMO_F_IMM_LO        6

// Opcodes
`define CMO_OP_WBINV_HIT    6'h1B
`define CMO_OP_INV_HIT      6'h13
`define CMO_OP_INV_IDX      6'h33
`define CMO_OP_WBINV_IDX    6'h3B
`define CMO_OP_RTYPE        6'h3A
`define CMO_OPX_INV_I       6'h0C
`define CMO_OPX_FLUSH_P     6'h04

// Cache geometry: 8 lines of 4 words
`define CMO_LINES           8
`define CMO_LINE_HI         6
`define CMO_LINE_LO         4
`define CMO_WORD_HI         3
`define CMO_WORD_LO         2
`define CMO_TAG_HI          31
`define CMO_TAG_LO          7
`define CMO_TAG_W           25
`define CMO_LAST_BEAT       2'h3

// Exception codes
`define CMO_EXC_NONE        3'h0
`define CMO_EXC_SUPER       3'h1
`define CMO_EXC_FAST_TLB    3'h2
`define CMO_EXC_DOUBLE_TLB  3'h3
`define CMO_EXC_MPU         3'h4
`define CMO_EXC_UNIMPL      3'h5

`endif

// >>> cmo_decode.v
`timescale 1ns/1ps
`default_nettype none
`include "cmo_regs.vh"

module cmo_decode (
  // Instruction and operand
  input  wire [31:0] instr,
  input  wire [31:0] a_value,
  // Decoded kind and address
  output reg         is_wbinv_hit,
  output reg         is_inv_hit,
  output reg         is_inv_idx,
  output reg         is_wbinv_idx,
  output reg         is_inv_i,
  output reg         is_flush_p,
  output wire [31:0] ea
);

  function [31:0] sext16;
    input [15:0] v;
    begin
      sext16 = {{16{v[15]}}, v};
    end
  endfunction

  wire [5:0]  opcode             = instr[`CMO_F_OP_HI:`CMO_F_OP_LO];
  wire [5:0]  opx                = instr[`CMO_F_OPX_HI:`CMO_F_OPX_LO];
  wire [4:0]  fld_a              = instr[`CMO_F_A_HI:`CMO_F_A_LO];
  wire [4:0]  fld_b              = instr[`CMO_F_B_HI:`CMO_F_B_LO];
  wire [4:0]  fld_c              = instr[`CMO_F_C_HI:`CMO_F_C_LO];
  wire [15:0] signed_offset_field = instr[`CMO_F_IMM_HI:`CMO_F_IMM_LO];
  wire        b_zero             = (fld_b == 5'h00);
  wire        rtype              = (opcode == `CMO_OP_RTYPE) && b_zero && (fld_c == 5'h00)
                                   && (instr[10:6] == 5'h00);

  assign ea = a_value + sext16(signed_offset_field);

  always @* begin
    is_wbinv_hit = b_zero && (opcode == `CMO_OP_WBINV_HIT);
    is_inv_hit   = b_zero && (opcode == `CMO_OP_INV_HIT);
    is_inv_idx   = b_zero && (opcode == `CMO_OP_INV_IDX);
    is_wbinv_idx = b_zero && (opcode == `CMO_OP_WBINV_IDX);
    is_inv_i     = rtype && (opx == `CMO_OPX_INV_I);
    is_flush_p   = rtype && (opx == `CMO_OPX_FLUSH_P) && (fld_a == 5'h00);
  end

endmodule

`default_nettype wire

// >>> cmo_dcache_array.v
`timescale 1ns/1ps
`default_nettype none
`include "cmo_regs.vh"

module cmo_dcache_array (
  // Clock and reset
  input  wire                    clk,
  input  wire                    rst_n,
  input  wire                    ce,
  // Read port
  input  wire [2:0]              rd_line,
  output wire [`CMO_TAG_W-1:0]   rd_tag,
  output wire                    rd_valid,
  output wire                    rd_dirty,
  output wire [127:0]            rd_data,
  // Processor store
  input  wire                    st_we,
  input  wire [2:0]              st_line,
  input  wire [1:0]              st_word,
  input  wire [31:0]             st_data,
  // Line fill
  input  wire                    fill_we,
  input  wire [2:0]              fill_line,
  input  wire [`CMO_TAG_W-1:0]   fill_tag,
  input  wire [127:0]            fill_data,
  // Invalidate
  input  wire                    inv_we,
  input  wire [2:0]              inv_line
);

  reg [`CMO_TAG_W-1:0] tag_q   [0:`CMO_LINES-1];
  reg [127:0]          data_q  [0:`CMO_LINES-1];
  reg [`CMO_LINES-1:0] valid_q;
  reg [`CMO_LINES-1:0] dirty_q;
  integer              i;

  assign rd_tag   = tag_q[rd_line];
  assign rd_valid = valid_q[rd_line];
  assign rd_dirty = dirty_q[rd_line];
  assign rd_data  = data_q[rd_line];

  always @(posedge clk) begin
    if (!rst_n) begin
      valid_q <= 8'h00;
      dirty_q <= 8'h00;
      for (i = 0; i < `CMO_LINES; i = i + 1) begin
        tag_q[i]  <= 25'h0000000;
        data_q[i] <= 128'h0;
      end
    end else if (ce) begin
      // Clear first so that a same-cycle fill or store wins
      if (inv_we) begin
        valid_q[inv_line] <= 1'b0;
        dirty_q[inv_line] <= 1'b0;
      end
      if (fill_we) begin
        tag_q[fill_line]   <= fill_tag;
        data_q[fill_line]  <= fill_data;
        valid_q[fill_line] <= 1'b1;
        dirty_q[fill_line] <= 1'b0;
      end
      if (st_we) begin
        data_q[st_line][st_word*32 +: 32] <= st_data;
        dirty_q[st_line]                  <= 1'b1;
      end
    end
  end

endmodule

`default_nettype wire

// >>> cmo_top.v
`timescale 1ns/1ps
`default_nettype none
`include "cmo_regs.vh"

// How it works
// - Address is operand plus sign-extended offset
// - Direct-mapped cache, address splits tag and line
// - Hit flush-invalidate selects line, compares tag
// - Tag mismatch leaves cache and memory alone
// - Hit and dirty: write line back first
// - Store marks line dirty until written back or invalidated
// - Index ops always end clearing valid; hit ops only on a match without exception
// - No data cache: line ops are no-ops
// - Hit ops raise address and MMU exceptions
// - I-type opcodes 1B, 13, 33, 3B decoded
// - R-type 3A with extended 0C, 04
// - Instruction line invalidate by index, no exception
// - No instruction cache: invalidate is no-op
// - Pipeline flush discards prefetched instructions
// - Index invalidate ignores tag entirely
// - Index invalidate never writes back dirty data
// - Hit invalidate clears on match, no write-back
// - Index flush writes dirty line regardless
module cmo_top (
  // Clock, reset, enable
  input  wire         clk,
  input  wire         rst_n,
  input  wire         ce,
  // Wishbone slave
  input  wire         wb_cyc_i,
  input  wire         wb_stb_i,
  input  wire         wb_we_i,
  input  wire [7:0]   wb_adr_i,
  input  wire [3:0]   wb_sel_i,
  input  wire [31:0]  wb_dat_i,
  output reg  [31:0]  wb_dat_o,
  output reg          wb_ack_o,
  // Maintenance instruction stream
  input  wire         op_valid,
  output wire         op_ready,
  input  wire [31:0]  op_instr,
  input  wire [31:0]  operand_a_register,
  output reg          op_done,
  output reg  [2:0]   op_exc,
  output reg  [31:0]  op_ea,
  // Translation and protection answers for op_ea
  input  wire         mmu_fast_miss,
  input  wire         mmu_double_miss,
  input  wire         mpu_violation,
  // Processor stores into the data cache
  input  wire         st_valid,
  input  wire [31:0]  st_addr,
  input  wire [31:0]  st_data,
  output wire         st_stall,
  // Data cache line fill
  input  wire         fill_valid,
  input  wire [31:0]  fill_addr,
  input  wire [127:0] fill_data,
  // Instruction cache fill and maintenance
  input  wire         ifill_valid,
  input  wire [31:0]  ifill_addr,
  output reg          icache_inv,
  output reg  [2:0]   icache_inv_index,
  output reg          pipe_flush,
  // Write-back to memory
  output reg          mem_req,
  output reg  [31:0]  mem_addr,
  output reg  [31:0]  mem_data,
  input  wire         mem_ack
);

  localparam [3:0] S_IDLE  = 4'h1;
  localparam [3:0] S_LOOK  = 4'h2;
  localparam [3:0] S_WBACK = 4'h4;
  localparam [3:0] S_DONE  = 4'h8;

  function [2:0] line_of;
    input [31:0] a;
    begin
      line_of = a[`CMO_LINE_HI:`CMO_LINE_LO];
    end
  endfunction

  function [`CMO_TAG_W-1:0] tag_of;
    input [31:0] a;
    begin
      tag_of = a[`CMO_TAG_HI:`CMO_TAG_LO];
    end
  endfunction

  reg  [3:0]            state_q;
  reg  [5:0]            kind_q;
  reg  [1:0]            beat_q;
  reg  [`CMO_TAG_W-1:0] wb_tag_q;
  reg  [3:0]            ctrl_q;
  reg  [31:0]           opcnt_q;
  reg  [7:0]            ivalid_q;
  reg                   hit_q;
  reg                   inv_we;
  reg  [2:0]            exc_d;

  wire                  d_wbinv_hit;
  wire                  d_inv_hit;
  wire                  d_inv_idx;
  wire                  d_wbinv_idx;
  wire                  d_inv_i;
  wire                  d_flush_p;
  wire [31:0]           d_ea;
  wire [`CMO_TAG_W-1:0] rd_tag;
  wire                  rd_valid;
  wire                  rd_dirty;
  wire [127:0]          rd_data;

  wire idle     = (state_q == S_IDLE);
  wire has_dc   = ctrl_q[`CMO_CTRL_DCACHE];
  wire has_ic   = ctrl_q[`CMO_CTRL_ICACHE];
  wire [2:0] rd_line = idle ? line_of(st_addr) : line_of(op_ea);
  wire tag_hit  = rd_valid && (rd_tag == tag_of(op_ea));
  wire st_hit   = idle && st_valid && has_dc && rd_valid && (rd_tag == tag_of(st_addr));
  wire hit_op   = kind_q[0] || kind_q[1];
  wire op_take  = idle && op_valid;
  wire bus_req  = wb_cyc_i && wb_stb_i && !wb_ack_o;

  assign op_ready = idle;
  assign st_stall = !idle;

  cmo_decode u_dec (
    .instr        (op_instr),
    .a_value      (operand_a_register),
    .is_wbinv_hit (d_wbinv_hit),
    .is_inv_hit   (d_inv_hit),
    .is_inv_idx   (d_inv_idx),
    .is_wbinv_idx (d_wbinv_idx),
    .is_inv_i     (d_inv_i),
    .is_flush_p   (d_flush_p),
    .ea           (d_ea)
  );

  cmo_dcache_array u_arr (
    .clk       (clk),
    .rst_n     (rst_n),
    .ce        (ce),
    .rd_line   (rd_line),
    .rd_tag    (rd_tag),
    .rd_valid  (rd_valid),
    .rd_dirty  (rd_dirty),
    .rd_data   (rd_data),
    .st_we     (st_hit),
    .st_line   (line_of(st_addr)),
    .st_word   (st_addr[`CMO_WORD_HI:`CMO_WORD_LO]),
    .st_data   (st_data),
    .fill_we   (fill_valid && has_dc),
    .fill_line (line_of(fill_addr)),
    .fill_tag  (tag_of(fill_addr)),
    .fill_data (fill_data),
    .inv_we    (inv_we),
    .inv_line  (line_of(op_ea))
  );

  // Exception check for the hit-qualified operations
  always @* begin
    exc_d = `CMO_EXC_NONE;
    if (kind_q[1] && !ctrl_q[`CMO_CTRL_INVHIT_EN])
      exc_d = `CMO_EXC_UNIMPL;
    else if (ctrl_q[`CMO_CTRL_USER] && op_ea[31])
      exc_d = `CMO_EXC_SUPER;
    else if (mmu_double_miss)
      exc_d = `CMO_EXC_DOUBLE_TLB;
    else if (mmu_fast_miss)
      exc_d = `CMO_EXC_FAST_TLB;
    else if (mpu_violation)
      exc_d = `CMO_EXC_MPU;
  end

  // Decides when the selected line is invalidated
  always @* begin
    inv_we = 1'b0;
    if (state_q == S_LOOK && !(hit_op && exc_d != `CMO_EXC_NONE)) begin
      case (1'b1)
        kind_q[0]: inv_we = tag_hit && !rd_dirty;
        kind_q[1]: inv_we = tag_hit;
        kind_q[2]: inv_we = 1'b1;
        kind_q[3]: inv_we = !rd_dirty;
        default:   inv_we = 1'b0;
      endcase
    end else if (state_q == S_WBACK && mem_ack && beat_q == `CMO_LAST_BEAT) begin
      inv_we = 1'b1;
    end
  end

  // Operation sequencer
  always @(posedge clk) begin
    if (!rst_n) begin
      state_q          <= S_IDLE;
      kind_q           <= 6'h00;
      beat_q           <= 2'h0;
      wb_tag_q         <= 25'h0000000;
      hit_q            <= 1'b0;
      op_done          <= 1'b0;
      op_exc           <= `CMO_EXC_NONE;
      op_ea            <= 32'h00000000;
      icache_inv       <= 1'b0;
      icache_inv_index <= 3'h0;
      pipe_flush       <= 1'b0;
      mem_req          <= 1'b0;
      mem_addr         <= 32'h00000000;
      mem_data         <= 32'h00000000;
      ivalid_q         <= 8'h00;
      opcnt_q          <= 32'h00000000;
    end else if (ce) begin
      op_done    <= 1'b0;
      icache_inv <= 1'b0;
      pipe_flush <= 1'b0;
      case (state_q)
        S_IDLE: begin
          if (op_take) begin
            kind_q <= {d_flush_p, d_inv_i, d_wbinv_idx, d_inv_idx, d_inv_hit, d_wbinv_hit};
            op_ea  <= d_ea;
            op_exc <= `CMO_EXC_NONE;
            hit_q  <= 1'b0;
            if ((d_wbinv_hit || d_inv_hit || d_inv_idx || d_wbinv_idx) && has_dc) begin
              state_q <= S_LOOK;
            end else begin
              state_q <= S_DONE;
              if (d_inv_i && has_ic) begin
                icache_inv                           <= 1'b1;
                icache_inv_index                     <= line_of(operand_a_register);
                ivalid_q[line_of(operand_a_register)] <= 1'b0;
              end
              pipe_flush <= d_flush_p;
            end
          end
        end
        S_LOOK: begin
          hit_q <= tag_hit;
          if (hit_op && exc_d != `CMO_EXC_NONE) begin
            op_exc  <= exc_d;
            state_q <= S_DONE;
          end else if ((kind_q[0] && tag_hit && rd_dirty) || (kind_q[3] && rd_dirty)) begin
            state_q  <= S_WBACK;
            beat_q   <= 2'h0;
            wb_tag_q <= rd_tag;
            mem_req  <= 1'b1;
            mem_addr <= {rd_tag, line_of(op_ea), 2'h0, 2'h0};
            mem_data <= rd_data[31:0];
          end else begin
            state_q <= S_DONE;
          end
        end
        S_WBACK: begin
          if (mem_ack) begin
            if (beat_q == `CMO_LAST_BEAT) begin
              mem_req <= 1'b0;
              state_q <= S_DONE;
            end else begin
              beat_q   <= beat_q + 2'h1;
              mem_addr <= {wb_tag_q, line_of(op_ea), beat_q + 2'h1, 2'h0};
              mem_data <= rd_data[(beat_q + 2'h1)*32 +: 32];
            end
          end
        end
        S_DONE: begin
          op_done <= 1'b1;
          opcnt_q <= opcnt_q + 32'h00000001;
          state_q <= S_IDLE;
        end
        default: state_q <= S_IDLE;
      endcase
      // A fill beats an invalidate of the same instruction line
      if (ifill_valid && has_ic)
        ivalid_q[line_of(ifill_addr)] <= 1'b1;
    end
  end

  // Wishbone register slave, one wait state per access
  always @(posedge clk) begin
    if (!rst_n) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
      ctrl_q   <= `CMO_CTRL_RESET;
    end else if (ce) begin
      wb_ack_o <= bus_req;
      if (bus_req && wb_we_i && wb_adr_i == `CMO_REG_CTRL && wb_sel_i[0])
        ctrl_q <= wb_dat_i[3:0];
      if (bus_req && !wb_we_i) begin
        case (wb_adr_i)
          `CMO_REG_CTRL:    wb_dat_o <= {28'h0000000, ctrl_q};
          `CMO_REG_STATUS:  wb_dat_o <= {23'h000000, hit_q, 1'b0, op_exc, 3'h0, !idle};
          `CMO_REG_OPCOUNT: wb_dat_o <= opcnt_q;
          `CMO_REG_IVALID:  wb_dat_o <= {24'h000000, ivalid_q};
          default:          wb_dat_o <= 32'h00000000;
        endcase
      end
    end
  end

endmodule

`default_nettype wire

// >>> cmo_checker.sv
`timescale 1ns/1ps
`default_nettype none
`include "cmo_regs.vh"
module cmo_checker (
  // Clock and reset
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic        ce,
  // Register bus
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_ack_o,
  // Operations
  input wire logic        op_valid,
  input wire logic        op_ready,
  input wire logic [31:0] op_instr,
  input wire logic [31:0] operand_a_register,
  input wire logic        op_done,
  input wire logic [2:0]  op_exc,
  input wire logic [31:0] op_ea,
  input wire logic        st_stall,
  input wire logic        icache_inv,
  input wire logic [2:0]  icache_inv_index,
  input wire logic        pipe_flush,
  // Write-back
  input wire logic        mem_req,
  input wire logic [31:0] mem_addr,
  input wire logic [31:0] mem_data,
  input wire logic        mem_ack
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  wire         take = op_valid && op_ready && ce;
  wire  [5:0]  opc  = op_instr[5:0];
  wire         ityp = opc == `CMO_OP_WBINV_HIT || opc == `CMO_OP_INV_HIT ||
                      opc == `CMO_OP_INV_IDX || opc == `CMO_OP_WBINV_IDX;
  wire         is_fp = op_instr == {15'h0000, `CMO_OPX_FLUSH_P, 5'h00, `CMO_OP_RTYPE};
  logic [31:0] ea_q;
  logic [2:0]  line_q;
  // Address and line the sequencer should latch at a take
  always @(posedge clk) begin
    ea_q   <= operand_a_register + {{16{op_instr[21]}}, op_instr[21:6]};
    line_q <= operand_a_register[6:4];
  end
  AST_WB_ACK_NEXT: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o && ce |=> wb_ack_o)
    else $error("bus access not acknowledged in the next cycle");
  AST_EA_SUM: assert property (take && ityp |=> op_ea == ea_q)
    else $error("effective address is not operand plus signed offset");
  AST_FLUSHP_SEQ: assert property (
      take && is_fp |=> pipe_flush ##1 op_done && op_exc == 0)
    else $error("pipeline flush pulse or completion missing");
  AST_IINV_INDEX: assert property (
      icache_inv |-> icache_inv_index == line_q ##1 op_done)
    else $error("instruction line index wrong or no completion");
  AST_MEM_HOLD: assert property (
      mem_req && !mem_ack |=> mem_req && $stable(mem_addr) && $stable(mem_data))
    else $error("write-back beat changed before acknowledge");
  AST_MEM_STEP: assert property (
      mem_req && mem_ack && mem_addr[3:2] != 2'h3 |=>
      mem_req && mem_addr == $past(mem_addr) + 32'h4)
    else $error("write-back did not advance one word");
  AST_MEM_LAST: assert property (
      mem_req && mem_ack && mem_addr[3:2] == 2'h3 |=> !mem_req ##[0:1] op_done)
    else $error("write-back did not end after the last word");
  AST_MEM_ALIGN: assert property ($rose(mem_req) |-> mem_addr[3:0] == 4'h0)
    else $error("write-back did not start at word zero");
  AST_STALL_WB: assert property (mem_req |-> st_stall && !op_ready)
    else $error("stores or operations not held off during write-back");
  AST_DONE_PULSE: assert property (op_done |=> !op_done)
    else $error("completion lasted more than one cycle");
  AST_TAKE_ANSWER: assert property (take |-> ##[1:3] (op_done || mem_req))
    else $error("operation neither completed nor wrote back in time");
  COV_FLUSHP: cover property (take && is_fp);
  COV_LAST_BEAT: cover property (mem_req && mem_ack && mem_addr[3:2] == 2'h3);
  COV_EXC: cover property (op_done && op_exc != 0);
endmodule
bind cmo_top cmo_checker cmo_checker_inst (
  .clk, .rst_n, .ce, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .op_valid, .op_ready, .op_instr,
  .operand_a_register, .op_done, .op_exc, .op_ea, .st_stall, .icache_inv,
  .icache_inv_index, .pipe_flush, .mem_req, .mem_addr, .mem_data, .mem_ack
);
`default_nettype wire

// >>> cmo_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
module cmo_mem_model (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // Write-back port
  input  wire logic        mem_req,
  input  wire logic [31:0] mem_addr,
  input  wire logic [31:0] mem_data,
  output var  logic        mem_ack
);
  logic [31:0] wr_addr[$];
  logic [31:0] wr_data[$];
  logic [1:0]  wait_q;
  // One acknowledge per word, after one to three idle cycles
  always @(posedge clk) begin
    if (!rst_n) begin
      mem_ack <= 1'b0;
      wait_q  <= 2'h0;
    end else begin
      mem_ack <= 1'b0;
      if (mem_req && mem_ack) begin
        wr_addr.push_back(mem_addr);
        wr_data.push_back(mem_data);
      end
      if (mem_req && !mem_ack) begin
        if (wait_q == 2'h0) begin
          mem_ack <= 1'b1;
          wait_q  <= 2'($urandom % 3);
        end else begin
          wait_q <= wait_q - 2'h1;
        end
      end
    end
  end
endmodule
`default_nettype wire

// >>> cmo_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "cmo_regs.vh"
module cmo_top_tb;
  logic         clk = 1'b0, rst_n = 1'b0, ce = 1'b1;
  logic         wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0, wb_ack_o;
  logic [7:0]   wb_adr_i = 8'h00;
  logic [3:0]   wb_sel_i = 4'h0;
  logic [31:0]  wb_dat_i = 32'h0, wb_dat_o, op_ea, mem_addr, mem_data;
  logic         op_valid = 1'b0, st_valid = 1'b0, fill_valid = 1'b0, ifill_valid = 1'b0;
  logic         mmu_fast_miss = 1'b0, mmu_double_miss = 1'b0, mpu_violation = 1'b0;
  logic         op_ready, op_done, st_stall, icache_inv, pipe_flush, mem_req, mem_ack;
  logic [31:0]  op_instr = 32'h0, operand_a_register = 32'h0, st_addr = 32'h0;
  logic [31:0]  st_data = 32'h0, fill_addr = 32'h0, ifill_addr = 32'h0;
  logic [127:0] fill_data = 128'h0;
  logic [2:0]   op_exc, icache_inv_index;
  logic [5:0]   opcs [4] = '{`CMO_OP_WBINV_HIT, `CMO_OP_INV_HIT,
                             `CMO_OP_INV_IDX, `CMO_OP_WBINV_IDX};
  int           miscompares = 0, n_compared = 0, n_ops = 0, n_pf = 0, n_ii = 0;

  cmo_top cmo_top_inst (
    .clk, .rst_n, .ce, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
    .wb_dat_o, .wb_ack_o, .op_valid, .op_ready, .op_instr, .operand_a_register, .op_done,
    .op_exc, .op_ea, .mmu_fast_miss, .mmu_double_miss, .mpu_violation, .st_valid, .st_addr,
    .st_data, .st_stall, .fill_valid, .fill_addr, .fill_data, .ifill_valid, .ifill_addr,
    .icache_inv, .icache_inv_index, .pipe_flush, .mem_req, .mem_addr, .mem_data, .mem_ack
  );
  cmo_mem_model cmo_mem_model_inst (.clk, .rst_n, .mem_req, .mem_addr, .mem_data, .mem_ack);

  always #2.5 clk = ~clk;
  always @(posedge clk) begin
    n_pf += int'(pipe_flush === 1'b1);
    n_ii += int'(icache_inv === 1'b1);
  end

  function automatic logic [31:0] ity(input logic [5:0] opc, input logic [15:0] imm);
    return {5'h05, 5'h00, imm, opc};
  endfunction
  function automatic logic [31:0] rty(input logic [4:0] ra, input logic [5:0] opx);
    return {ra, 10'h000, opx, 5'h00, `CMO_OP_RTYPE};
  endfunction
  // Expected memory word: fill data with the stored word patched in
  function automatic logic [31:0] exp_word(input logic [127:0] fd, input logic [31:0] sw,
                                           input logic [1:0] ws, input int w);
    return (w == ws) ? sw : fd[32*w +: 32];
  endfunction

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wb_xfer(input logic we, input logic [7:0] adr, input logic [31:0] d,
                         output logic [31:0] q);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= adr;
    wb_dat_i <= d;
    wb_sel_i <= 4'hF;
    do
      @(posedge clk);
    while (wb_ack_o !== 1'b1);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clk);
  endtask
  task automatic op(input logic [31:0] ins, input logic [31:0] a);
    int n;
    n = 0;
    op_valid <= 1'b1;
    op_instr <= ins;
    operand_a_register <= a;
    do begin
      @(posedge clk);
      n++;
    end while (op_ready !== 1'b1 && n < 20);
    op_valid <= 1'b0;
    do begin
      @(posedge clk);
      n++;
    end while (op_done !== 1'b1 && n < 200);
    chk("op done", 32'h1, {31'h0, op_done});
    n_ops++;
  endtask
  // Kind 0 line fill, 1 store, 2 instruction line fill
  task automatic poke(input int kind, input logic [31:0] ad, input logic [127:0] d);
    case (kind)
      0: begin
        fill_valid <= 1'b1;
        fill_addr  <= ad;
        fill_data  <= d;
      end
      1: begin
        st_valid <= 1'b1;
        st_addr  <= ad;
        st_data  <= d[31:0];
      end
      default: begin
        ifill_valid <= 1'b1;
        ifill_addr  <= ad;
      end
    endcase
    @(posedge clk);
    fill_valid  <= 1'b0;
    st_valid    <= 1'b0;
    ifill_valid <= 1'b0;
    @(posedge clk);
  endtask
  task automatic chk_wb(input int base, input int nb, input logic [31:0] fa,
                        input logic [127:0] fd, input logic [31:0] sw);
    chk("beats", nb, cmo_mem_model_inst.wr_addr.size() - base);
    for (int i = 0; i < nb && base + i < cmo_mem_model_inst.wr_addr.size(); i++) begin
      chk("wb addr", {fa[31:4], 4'(i * 4)}, cmo_mem_model_inst.wr_addr[base+i]);
      chk("wb data", exp_word(fd, sw, fa[3:2], i), cmo_mem_model_inst.wr_data[base+i]);
    end
  endtask
  task automatic final_report;
    $display("compared %0d mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    miscompares++;
    final_report();
  end

  initial begin
    logic [31:0]  a, ea, fa, q, sw;
    logic [15:0]  imm;
    logic [127:0] fd;
    int           k, base, nb;
    q = $urandom(32'hB7847127);
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    wb_xfer(1'b0, `CMO_REG_CTRL, 32'h0, q);
    chk("ctrl", 32'hB, q);
    wb_xfer(1'b1, `CMO_REG_STATUS, 32'hFFFF_FFFF, q);
    wb_xfer(1'b0, `CMO_REG_STATUS, 32'h0, q);
    chk("status", 32'h0, q);
    wb_xfer(1'b0, 8'h10, 32'h0, q);
    chk("unmapped", 32'h0, q);
    for (int i = 0; i < 8; i++)
      op(ity(`CMO_OP_INV_IDX, 16'h0), 32'(i * 16));
    // Each line operation on a hit and on a tag mismatch, dirty line
    for (int t = 0; t < 24; t++) begin
      k = t % 4;
      a = $urandom;
      imm = 16'($urandom);
      sw = $urandom;
      fd = {$urandom, $urandom, $urandom, $urandom};
      ea = a + {{16{imm[15]}}, imm};
      fa = {ea[31:7] ^ {24'h0, t[2]}, ea[6:0]};
      poke(0, fa, fd);
      poke(1, fa, {96'h0, sw});
      base = cmo_mem_model_inst.wr_addr.size();
      op(ity(opcs[k], imm), a);
      nb = (k == 0 && !t[2]) || k == 3 ? 4 : 0;
      chk_wb(base, nb, fa, fd, sw);
      chk("exc", 32'h0, {29'h0, op_exc});
      poke(1, fa, {96'h0, sw});
      base = cmo_mem_model_inst.wr_addr.size();
      op(ity(`CMO_OP_WBINV_IDX, imm), a);
      chk_wb(base, (t[2] && k < 2) ? 4 : 0, fa, fd, sw);
    end
    // Exception codes of the hit operations
    for (int e = 1; e <= 5; e++) begin
      wb_xfer(1'b1, `CMO_REG_CTRL, e == 1 ? 32'hF : e == 5 ? 32'h3 : 32'hB, q);
      mmu_fast_miss   <= e == 2;
      mmu_double_miss <= e == 3;
      mpu_violation   <= e == 4;
      op(ity(e == 5 ? `CMO_OP_INV_HIT : `CMO_OP_WBINV_HIT, 16'h0), 32'h8000_0040);
      chk("exc code", 32'(e), {29'h0, op_exc});
    end
    mmu_fast_miss   <= 1'b0;
    mmu_double_miss <= 1'b0;
    mpu_violation   <= 1'b0;
    // Without a data cache the line operations change nothing
    fa = 32'h0000_1234;
    fd = {4{32'hA5A5_0F0F}};
    poke(0, fa, fd);
    poke(1, fa, 128'h1234_5678);
    wb_xfer(1'b1, `CMO_REG_CTRL, 32'hA, q);
    base = cmo_mem_model_inst.wr_addr.size();
    op(ity(`CMO_OP_WBINV_IDX, 16'h0), fa);
    op(ity(`CMO_OP_INV_IDX, 16'h0), fa);
    chk_wb(base, 0, fa, fd, 32'h1234_5678);
    wb_xfer(1'b1, `CMO_REG_CTRL, 32'hB, q);
    op(ity(`CMO_OP_WBINV_IDX, 16'h0), fa);
    chk_wb(base, 4, fa, fd, 32'h1234_5678);
    wb_xfer(1'b0, `CMO_REG_STATUS, 32'h0, q);
    chk("status hit", 32'h100, q);
    // Instruction line invalidate with and without an instruction cache
    poke(2, 32'h0000_0050, 128'h0);
    wb_xfer(1'b0, `CMO_REG_IVALID, 32'h0, q);
    chk("ivalid", 32'h20, q);
    op(rty(5'h05, `CMO_OPX_INV_I), 32'hFFFF_FF5C);
    chk("iinv index", 32'h5, {29'h0, icache_inv_index});
    chk("iinv exc", 32'h0, {29'h0, op_exc});
    wb_xfer(1'b0, `CMO_REG_IVALID, 32'h0, q);
    chk("ivalid", 32'h0, q);
    poke(2, 32'h0000_0070, 128'h0);
    wb_xfer(1'b1, `CMO_REG_CTRL, 32'h9, q);
    op(rty(5'h05, `CMO_OPX_INV_I), 32'h0000_0070);
    wb_xfer(1'b0, `CMO_REG_IVALID, 32'h0, q);
    chk("ivalid", 32'h80, q);
    chk("iinv pulses", 32'h1, 32'(n_ii));
    wb_xfer(1'b1, `CMO_REG_CTRL, 32'hB, q);
    op(rty(5'h00, `CMO_OPX_FLUSH_P), 32'h0);
    chk("flush pulses", 32'h1, 32'(n_pf));
    chk("flush exc", 32'h0, {29'h0, op_exc});
    // An unrecognised instruction completes with no effect
    op(32'h0000_0000, 32'h0000_0000);
    chk("unknown exc", 32'h0, {29'h0, op_exc});
    wb_xfer(1'b0, `CMO_REG_OPCOUNT, 32'h0, q);
    chk("opcount", 32'(n_ops), q);
    final_report();
  end
endmodule
`default_nettype wire
